//--- rtl/ircrsa_consts.vh
// Constants for the clock and control register slave access block
`ifndef IRCRSA_CONSTS_VH
`define IRCRSA_CONSTS_VH
// Seven-bit slave addresses of the two register spaces
`define IRCRSA_SADDR_RTC   7'h68
`define IRCRSA_SADDR_CTRL  7'h18
// Clock register space
`define IRCRSA_RTC_LAST    8'h0F
// Control register space
`define IRCRSA_MEM_CTRL    8'h00
`define IRCRSA_SN_FIRST    8'h01
`define IRCRSA_SN_LAST     8'h08
`define IRCRSA_ID_FIRST    8'h09
`define IRCRSA_CTRL_LAST   8'h0C
`define IRCRSA_CMD_ENTRY   8'hAA
// Memory control fields and reset values
`define IRCRSA_MC_LOCK_BIT 6
`define IRCRSA_MC_SAVE_BIT 1
`define IRCRSA_MC_RESET    8'h00
`define IRCRSA_SN_RESET    8'h00
// Bit slot counts of one byte on the link
`define IRCRSA_ACK_SLOT    4'h8
`define IRCRSA_END_SLOT    4'h9
`endif

//--- rtl/ircrsa_slave.v
// Serial link slave for the clock register space and the control register space
`default_nettype none
`include "ircrsa_consts.vh"

// Functional notes
// - Clock register writes advance the counter per byte, wrapping to zero.
// - A register is written only after all eight data bits, then acknowledged.
// - Out-of-range clock write address is NACKed; counter left unchanged.
// - Current clock read starts after the last access and wraps to zero.
// - Random read loads the counter with the written address.
// - Out-of-range clock random read address is NACKed; counter unchanged.
// - Data to a non-writable control location is NACKed; write ends, no increment.
// - After a command write the next control read starts at zero.
// - Out-of-range control write address is NACKed after the address byte.
// - With lock set only command and memory control accept data.
// - Control reads wrap to zero after the last readable byte, skipping command.
// - Out-of-range control random read address is NACKed.
// - Eight serial bytes at one to eight, reset to zero, no checksum.
// - Serial bytes are copied to nonvolatile image on each save.
// - Unlocked serial bytes rewrite freely; locked ones NACK the data.
// - Without a save, lock and serial bytes come up zero.
// - Serial bytes read back their current values in any lock state.
// - Unknown command codes are acknowledged; address rolls over to zero.
// - While a command runs, every slave address selection is NACKed.
module ircrsa_slave #(
    parameter [31:0] DEVICE_ID = 32'h0A5C3E10  // Arbitrary neutral value
) (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_b,
    // Nonvolatile image clear, a fresh part
    input  wire        nv_rst_b,
    // Serial link pins
    input  wire        scl_i,
    input  wire        sda_i,
    output wire        sda_o,
    output wire        sda_oe,
    // Clock register file outside this block
    output wire [3:0]  rtc_raddr,
    input  wire [7:0]  rtc_rdata,
    output wire        rtc_we,
    output wire [3:0]  rtc_waddr,
    output wire [7:0]  rtc_wdata,
    // Command executor
    output wire        cmd_strobe,
    output wire [7:0]  cmd_code,
    input  wire        cmd_busy,
    // Save requests and state
    input  wire        store_req,
    input  wire        power_fail,
    output wire [7:0]  mem_control,
    output wire        serial_lock_flag
);
    localparam ST_IDLE = 3'h0;
    localparam ST_DEV  = 3'h1;
    localparam ST_ADDR = 3'h2;
    localparam ST_WR   = 3'h3;
    localparam ST_RD   = 3'h4;
    localparam ST_SKIP = 3'h5;

    reg  [1:0] rst_sync_ff;
    wire       rst_n;
    reg        scl_s1_ff, scl_s2_ff, scl_d_ff;
    reg        sda_s1_ff, sda_s2_ff, sda_d_ff;
    reg        pf_s1_ff, pf_s2_ff, pf_d_ff;
    reg  [2:0] state_ff;
    reg  [3:0] bit_ff;
    reg  [7:0] rx_ff;
    reg  [7:0] tx_ff;
    reg        oe_ff;
    reg        space_ff;                    // 1 for control space
    reg        mnack_ff;
    reg  [3:0] rtc_cnt_ff;
    reg  [7:0] ctl_cnt_ff;
    reg        rtc_we_ff;
    reg  [3:0] rtc_waddr_ff;
    reg  [7:0] rtc_wdata_ff;
    reg        cmd_strobe_ff;
    reg  [7:0] cmd_code_ff;
    reg  [7:0] mc_ff;
    reg  [7:0] nv_mc_ff;
    reg        recall_ff;
    reg  [7:0] sn_ff [1:8];
    reg  [7:0] ctl_rdata;
    wire       start_ev, stop_ev, rise_ev, fall_ev;
    wire       byte_done, ack_end;
    wire       lock;
    wire       save_now;
    wire [7:0] ctl_eff;
    wire [7:0] ctl_next;
    wire       ctl_wr, wr_mc, wr_sn, wr_cmd;
    wire       ctl_addr_ok;
    genvar     gi;

    // Reset release through two flops
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // Pin synchronisers; the third stage only serves edge detection
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {scl_s1_ff, scl_s2_ff, scl_d_ff} <= 3'h7;
            {sda_s1_ff, sda_s2_ff, sda_d_ff} <= 3'h7;
            {pf_s1_ff, pf_s2_ff, pf_d_ff}    <= 3'h0;
        end else begin
            {scl_s1_ff, scl_s2_ff, scl_d_ff} <= {scl_i, scl_s1_ff, scl_s2_ff};
            {sda_s1_ff, sda_s2_ff, sda_d_ff} <= {sda_i, sda_s1_ff, sda_s2_ff};
            {pf_s1_ff, pf_s2_ff, pf_d_ff}    <= {power_fail, pf_s1_ff, pf_s2_ff};
        end
    end

    // Bus conditions seen on the sampled pins
    assign start_ev  = scl_s2_ff & scl_d_ff & sda_d_ff & ~sda_s2_ff;
    assign stop_ev   = scl_s2_ff & scl_d_ff & ~sda_d_ff & sda_s2_ff;
    assign rise_ev   = scl_s2_ff & ~scl_d_ff;
    assign fall_ev   = ~scl_s2_ff & scl_d_ff;
    assign byte_done = fall_ev && (bit_ff == `IRCRSA_ACK_SLOT);
    assign ack_end   = fall_ev && (bit_ff == `IRCRSA_END_SLOT);

    // Control space decode
    assign lock        = mc_ff[`IRCRSA_MC_LOCK_BIT];
    assign ctl_addr_ok = (rx_ff <= `IRCRSA_CTRL_LAST) || (rx_ff == `IRCRSA_CMD_ENTRY);
    assign ctl_wr = byte_done && (state_ff == ST_WR) && space_ff;
    assign wr_mc  = ctl_wr && (ctl_cnt_ff == `IRCRSA_MEM_CTRL);
    assign wr_cmd = ctl_wr && (ctl_cnt_ff == `IRCRSA_CMD_ENTRY);
    assign wr_sn  = ctl_wr && !lock && (ctl_cnt_ff >= `IRCRSA_SN_FIRST)
                    && (ctl_cnt_ff <= `IRCRSA_SN_LAST);

    // Reads past the last readable byte, command entry included, restart at zero
    assign ctl_eff  = (ctl_cnt_ff > `IRCRSA_CTRL_LAST) ? `IRCRSA_MEM_CTRL : ctl_cnt_ff;
    assign ctl_next = (ctl_eff == `IRCRSA_CTRL_LAST) ? `IRCRSA_MEM_CTRL : ctl_eff + 8'h01;

    // Control read data; serial bytes show live values in any lock state
    always @* begin
        case (ctl_eff)
            8'h00:   ctl_rdata = mc_ff;
            8'h09:   ctl_rdata = DEVICE_ID[31:24];
            8'h0A:   ctl_rdata = DEVICE_ID[23:16];
            8'h0B:   ctl_rdata = DEVICE_ID[15:8];
            8'h0C:   ctl_rdata = DEVICE_ID[7:0];
            default: ctl_rdata = sn_ff[ctl_eff[3:0]];
        endcase
    end

    // Save on request, or at power loss when automatic saving is on
    assign save_now = store_req | (pf_s2_ff & ~pf_d_ff & mc_ff[`IRCRSA_MC_SAVE_BIT]);

    // Serial bytes and their nonvolatile image, one per entry
    generate
        for (gi = 1; gi <= 8; gi = gi + 1) begin : g_sn
            reg [7:0] nv_ff;
            always @(posedge clk or negedge nv_rst_b) begin
                if (!nv_rst_b) begin
                    nv_ff <= `IRCRSA_SN_RESET;
                end else if (save_now) begin
                    nv_ff <= sn_ff[gi];
                end
            end
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    sn_ff[gi] <= `IRCRSA_SN_RESET;
                end else if (recall_ff) begin
                    sn_ff[gi] <= nv_ff;
                end else if (wr_sn && (ctl_cnt_ff[3:0] == gi)) begin
                    sn_ff[gi] <= rx_ff;
                end
            end
        end
    endgenerate

    // Memory control image survives only through a save
    always @(posedge clk or negedge nv_rst_b) begin
        if (!nv_rst_b) begin
            nv_mc_ff <= `IRCRSA_MC_RESET;
        end else if (save_now) begin
            nv_mc_ff <= mc_ff;
        end
    end

    // Live memory control, recalled once after reset release
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mc_ff     <= `IRCRSA_MC_RESET;
            recall_ff <= 1'b1;
        end else begin
            recall_ff <= 1'b0;
            if (recall_ff) begin
                mc_ff <= nv_mc_ff;
            end else if (wr_mc) begin
                mc_ff <= rx_ff;
            end
        end
    end

    // Link protocol engine and the two address counters
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff      <= ST_IDLE;
            bit_ff        <= 4'h0;
            rx_ff         <= 8'h00;
            tx_ff         <= 8'h00;
            oe_ff         <= 1'b0;
            space_ff      <= 1'b0;
            mnack_ff      <= 1'b0;
            rtc_cnt_ff    <= 4'h0;
            ctl_cnt_ff    <= 8'h00;
            rtc_we_ff     <= 1'b0;
            rtc_waddr_ff  <= 4'h0;
            rtc_wdata_ff  <= 8'h00;
            cmd_strobe_ff <= 1'b0;
            cmd_code_ff   <= 8'h00;
        end else begin
            rtc_we_ff     <= 1'b0;
            cmd_strobe_ff <= 1'b0;
            if (start_ev) begin
                // Repeated START abandons a partial byte unwritten
                state_ff <= ST_DEV;
                bit_ff   <= 4'h0;
                oe_ff    <= 1'b0;
            end else if (stop_ev) begin
                state_ff <= ST_IDLE;
                oe_ff    <= 1'b0;
            end else if (rise_ev && state_ff != ST_IDLE && state_ff != ST_SKIP) begin
                if (bit_ff < `IRCRSA_ACK_SLOT) begin
                    rx_ff  <= {rx_ff[6:0], sda_s2_ff};
                    bit_ff <= bit_ff + 4'h1;
                end else if (bit_ff == `IRCRSA_ACK_SLOT) begin
                    mnack_ff <= sda_s2_ff;
                    bit_ff   <= `IRCRSA_END_SLOT;
                end
            end else if (fall_ev && state_ff == ST_RD && bit_ff != 4'h0 && bit_ff < `IRCRSA_ACK_SLOT) begin
                tx_ff <= {tx_ff[6:0], 1'b0};
                oe_ff <= ~tx_ff[6];
            end else if (byte_done) begin
                oe_ff <= 1'b0;
                case (state_ff)
                    ST_DEV: begin
                        if ((rx_ff[7:1] == `IRCRSA_SADDR_RTC || rx_ff[7:1] == `IRCRSA_SADDR_CTRL)
                            && !cmd_busy) begin
                            oe_ff    <= 1'b1;
                            space_ff <= (rx_ff[7:1] == `IRCRSA_SADDR_CTRL);
                            state_ff <= rx_ff[0] ? ST_RD : ST_ADDR;
                        end else begin
                            state_ff <= ST_SKIP;
                        end
                    end
                    ST_ADDR: begin
                        // Each space loads only its own counter
                        if (!space_ff && rx_ff <= `IRCRSA_RTC_LAST) begin
                            oe_ff      <= 1'b1;
                            rtc_cnt_ff <= rx_ff[3:0];
                            state_ff   <= ST_WR;
                        end else if (space_ff && ctl_addr_ok) begin
                            oe_ff      <= 1'b1;
                            ctl_cnt_ff <= rx_ff;
                            state_ff   <= ST_WR;
                        end else begin
                            state_ff <= ST_SKIP;
                        end
                    end
                    ST_WR: begin
                        if (!space_ff) begin
                            oe_ff        <= 1'b1;
                            rtc_we_ff    <= 1'b1;
                            rtc_waddr_ff <= rtc_cnt_ff;
                            rtc_wdata_ff <= rx_ff;
                            rtc_cnt_ff   <= rtc_cnt_ff + 4'h1;
                        end else if (wr_cmd) begin
                            // Any code is taken; unknown ones do nothing outside
                            oe_ff         <= 1'b1;
                            cmd_strobe_ff <= 1'b1;
                            cmd_code_ff   <= rx_ff;
                            ctl_cnt_ff    <= `IRCRSA_MEM_CTRL;
                        end else if (wr_mc || wr_sn) begin
                            oe_ff      <= 1'b1;
                            ctl_cnt_ff <= ctl_cnt_ff + 8'h01;
                        end else begin
                            state_ff <= ST_SKIP;
                        end
                    end
                    default: begin
                        oe_ff <= 1'b0;
                    end
                endcase
            end else if (ack_end) begin
                bit_ff <= 4'h0;
                oe_ff  <= 1'b0;
                if (state_ff == ST_RD && mnack_ff && !oe_ff) begin
                    state_ff <= ST_SKIP;
                end else if (state_ff == ST_RD) begin
                    // Counter points past the byte handed out
                    if (space_ff) begin
                        tx_ff      <= ctl_rdata;
                        oe_ff      <= ~ctl_rdata[7];
                        ctl_cnt_ff <= ctl_next;
                    end else begin
                        tx_ff      <= rtc_rdata;
                        oe_ff      <= ~rtc_rdata[7];
                        rtc_cnt_ff <= rtc_cnt_ff + 4'h1;
                    end
                end
            end
        end
    end

    // Open-drain drive: the pin is only ever pulled low
    assign sda_o            = 1'b0;
    assign sda_oe           = oe_ff;
    assign rtc_raddr        = rtc_cnt_ff;
    assign rtc_we           = rtc_we_ff;
    assign rtc_waddr        = rtc_waddr_ff;
    assign rtc_wdata        = rtc_wdata_ff;
    assign cmd_strobe       = cmd_strobe_ff;
    assign cmd_code         = cmd_code_ff;
    assign mem_control      = mc_ff;
    assign serial_lock_flag = mc_ff[`IRCRSA_MC_LOCK_BIT];
endmodule
`default_nettype wire

//--- testbench/ircrsa_slave_asserts.sv
// Port assertions for the register slave
`default_nettype none
`include "ircrsa_consts.vh"
module ircrsa_slave_asserts (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst_b,
    // Link and command handshake
    input wire logic       scl_i,
    input wire logic       sda_oe,
    input wire logic       cmd_strobe,
    input wire logic       cmd_busy,
    // Clock register port and control state
    input wire logic [3:0] rtc_raddr,
    input wire logic       rtc_we,
    input wire logic [3:0] rtc_waddr,
    input wire logic [7:0] mem_control,
    input wire logic       serial_lock_flag
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] rel_ff;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Settle count; the recall after reset loads memory control outside any transfer
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) rel_ff <= 4'h0;
        else if (rel_ff != 4'hF) rel_ff <= rel_ff + 4'h1;
    end
    chk_we_ack: assert property (rtc_we |-> sda_oe) else $error("commit without acknowledge");
    chk_we_next: assert property (rtc_we |-> ##[0:8] rtc_raddr == rtc_waddr + 4'h1)
        else $error("clock counter did not step");
    chk_cmd_ack: assert property (cmd_strobe |-> sda_oe ##1 !cmd_strobe) else $error("bad command strobe");
    chk_busy_nack: assert property (cmd_busy && $past(cmd_busy) |-> !sda_oe) else $error("answer while busy");
    chk_lock_set: assert property (rel_ff == 4'hF && $rose(serial_lock_flag) |-> sda_oe)
        else $error("lock set outside a write");
    chk_sda_stable: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe)) else $error("data moved at clock high");
    chk_reset_zero: assert property (disable iff (1'b0) !rst_b |-> mem_control == 8'h00)
        else $error("control not cleared");
    chk_mc_commit: assert property (rel_ff == 4'hF && $changed(mem_control) |-> ##[0:1] sda_oe)
        else $error("control changed outside a write");
    cover property (rtc_we);
    cover property (cmd_strobe);
    cover property ($rose(serial_lock_flag));
endmodule
`default_nettype wire

//--- testbench/ircrsa_mst.sv
// Behavioural I2C master model; SCL stands high between frames
`default_nettype none
module ircrsa_mst (
    // Clock and link
    input  wire logic clk,
    input  wire logic sda,
    output var  logic scl,
    output var  logic sda_drv
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Start or repeated start; SDA falls only while SCL is high.
    // SDA is let go inside the low phase so the slave's acknowledge ends before SCL rises
    task automatic start();
        wt(2);
        sda_drv <= 1'b1;
        wt(2);
        scl <= 1'b1;
        wt(2);
        sda_drv <= 1'b0;
        wt(4);
        scl <= 1'b0;
    endtask
    task automatic stop();
        wt(2);
        sda_drv <= 1'b0;
        wt(2);
        scl <= 1'b1;
        wt(2);
        sda_drv <= 1'b1;
        wt(4);
    endtask
    // One bit: data moves mid low phase, sampled mid high phase
    task automatic bit_io(input logic b, output logic s);
        wt(2);
        sda_drv <= b;
        wt(2);
        scl <= 1'b1;
        wt(2);
        s = sda;
        wt(2);
        scl <= 1'b0;
    endtask
    // Fewer than eight bits leaves a byte unfinished for a caller to abandon
    task automatic wb(input logic [7:0] d, input int n, output logic ak);
        logic s;
        for (int i = 7; i > 7 - n; i--) bit_io(d[i], s);
        if (n == 8) bit_io(1'b1, s);
        ak = ~s;
    endtask
    task automatic rb(output logic [7:0] d, input logic last);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(last, s);
    endtask
endmodule
`default_nettype wire

//--- testbench/test_ircrsa_slave.sv
// Self-checking bench for the register slave
`default_nettype none
`include "ircrsa_consts.vh"
module test_ircrsa_slave;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] ID = 32'h5A3C96E1; // Arbitrary identity value
    logic       clk = 1'b0, rst_b = 1'b1, nv_rst_b = 1'b0, cmd_busy = 1'b0, store_req = 1'b0, power_fail = 1'b0;
    logic       scl, sda_drv, sda_o, sda_oe, rtc_we, cmd_strobe, lock, ak;
    logic [3:0] rtc_raddr, rtc_waddr;
    logic [7:0] rtc_rdata, rtc_wdata, cmd_code, mem_ctl, mc = 8'h00, nmc = 8'h00;
    logic [7:0] rf [16] = '{default: 8'h00}, mr [16] = '{default: 8'h00};
    logic [7:0] sn [1:8] = '{default: 8'h00}, nsn [1:8] = '{default: 8'h00};
    int         err_total = 0, num_checks = 0, cyc = 0, rc = 0, cc = 0, stb = 0, ncmd = 0;
    wire logic  sda = sda_drv & ~sda_oe; // Open-drain wire with pull-up
    ircrsa_slave #(.DEVICE_ID(ID)) u_ircrsa_slave (
        .clk(clk), .rst_b(rst_b), .nv_rst_b(nv_rst_b), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .rtc_raddr(rtc_raddr), .rtc_rdata(rtc_rdata), .rtc_we(rtc_we), .rtc_waddr(rtc_waddr), .rtc_wdata(rtc_wdata),
        .cmd_strobe(cmd_strobe), .cmd_code(cmd_code), .cmd_busy(cmd_busy), .store_req(store_req),
        .power_fail(power_fail), .mem_control(mem_ctl), .serial_lock_flag(lock));
    ircrsa_mst u_ircrsa_mst (.clk(clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
    always #50 clk = ~clk;
    // Clock register file outside the block
    assign rtc_rdata = rf[rtc_raddr];
    always @(posedge clk) begin
        if (rtc_we) rf[rtc_waddr] <= rtc_wdata;
        // Strobe pulses are counted since the pulse is gone before a task can look
        if (cmd_strobe) stb <= stb + 1;
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            test_done();
        end
    end
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic test_done();
        if (err_total == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    function automatic logic okad(input logic c, input logic [7:0] a);
        return c ? (a <= `IRCRSA_CTRL_LAST || a == `IRCRSA_CMD_ENTRY) : a <= `IRCRSA_RTC_LAST;
    endfunction
    function automatic logic [7:0] cv(input int a);
        if (a == 0) return mc;
        if (a <= 8) return sn[a];
        return ID[8 * (12 - a) +: 8];
    endfunction
    // Header, address, n bytes (first fixed when f is not negative); STOP unless stp is low and the address is in range
    task automatic w(input logic c, input logic [7:0] a, input int n, input logic stp, input int f);
        logic [7:0] d;
        int         p;
        logic       e;
        p = c ? cc : rc;
        e = okad(c, a);
        u_ircrsa_mst.start();
        u_ircrsa_mst.wb({c ? `IRCRSA_SADDR_CTRL : `IRCRSA_SADDR_RTC, 1'b0}, 8, ak);
        chk("hdr_ack", ak, 1'b1);
        u_ircrsa_mst.wb(a, 8, ak);
        chk("addr_ack", ak, e);
        if (e) p = a;
        for (int i = 0; i < n && e; i++) begin
            d = (i == 0 && f >= 0) ? f[7:0] : 8'($urandom);
            e = !c || p == 'hAA || p == 0 || (p <= 8 && !mc[6]);
            u_ircrsa_mst.wb(d, 8, ak);
            chk("data_ack", ak, e);
            if (!c) mr[p] = d;
            if (c && p == 0) mc = d;
            if (c && p >= 1 && p <= 8 && e) sn[p] = d;
            if (c && p == 'hAA) chk("cmd_code", cmd_code, d);
            if (c && p == 'hAA) ncmd++;
            if (c && p == 'hAA) chk("cmd_strobe", stb, ncmd);
            if (e) p = !c ? (p + 1) % 16 : p == 'hAA ? 0 : p + 1;
        end
        if (c) cc = p;
        else rc = p;
        if (stp || !okad(c, a)) u_ircrsa_mst.stop();
        chk("mem_ctl", mem_ctl, mc);
        chk("lock", lock, mc[6]);
    endtask
    task automatic r(input logic c, input int n);
        logic [7:0] d;
        u_ircrsa_mst.start();
        u_ircrsa_mst.wb({c ? `IRCRSA_SADDR_CTRL : `IRCRSA_SADDR_RTC, 1'b1}, 8, ak);
        chk("rhdr_ack", ak, 1'b1);
        for (int i = 0; i < n; i++) begin
            u_ircrsa_mst.rb(d, i == n - 1);
            if (c && cc > 12) cc = 0;
            if (c) chk("ctl_rd", d, cv(cc));
            else chk("rtc_rd", d, mr[rc]);
            if (c) cc = cc == 12 ? 0 : cc + 1;
            else rc = (rc + 1) % 16;
        end
        u_ircrsa_mst.stop();
    endtask
    task automatic rr(input logic c, input logic [7:0] a, input int n);
        w(c, a, 0, 1'b0, -1);
        if (okad(c, a)) r(c, n);
    endtask
    // Power cycle: live state comes back from the saved image, counters from zero
    task automatic pcyc();
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge clk);
        mc = nmc;
        sn = nsn;
        rc = 0;
        cc = 0;
    endtask
    initial begin
        void'($urandom(35));
        // A real falling edge at time zero so the asynchronous resets act at once
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        nv_rst_b <= 1'b1;
        repeat (6) @(posedge clk);
        rr(1, 8'h00, 14);
        w(0, 8'h0E, 3, 1'b1, -1);
        r(0, 2);
        w(0, 8'h10, 1, 1'b1, -1);
        r(0, 1);
        rr(0, 8'h3F, 1);
        rr(0, 8'h0F, 2);
        w(0, 8'h05, 0, 1'b0, -1);
        u_ircrsa_mst.wb(8'h96, 4, ak);
        u_ircrsa_mst.stop();
        r(0, 1);
        w(1, 8'h01, 9, 1'b1, -1);
        r(1, 2);
        w(1, 8'hAA, 1, 1'b1, -1);
        r(1, 1);
        w(1, 8'h0D, 1, 1'b1, -1);
        rr(1, 8'h0D, 1);
        rr(1, 8'hAA, 2);
        pcyc();
        r(1, 9);
        w(1, 8'h01, 8, 1'b1, -1);
        w(1, 8'h00, 2, 1'b1, 8'h40);
        w(1, 8'hAA, 1, 1'b1, -1);
        store_req <= 1'b1;
        @(posedge clk);
        store_req <= 1'b0;
        nmc = mc;
        nsn = sn;
        pcyc();
        rr(1, 8'h00, 9);
        w(1, 8'h00, 3, 1'b1, 8'h02);
        power_fail <= 1'b1;
        repeat (4) @(posedge clk);
        power_fail <= 1'b0;
        nmc = mc;
        nsn = sn;
        pcyc();
        r(1, 9);
        cmd_busy <= 1'b1;
        u_ircrsa_mst.start();
        u_ircrsa_mst.wb({`IRCRSA_SADDR_RTC, 1'b0}, 8, ak);
        chk("busy_ack", ak, 1'b0);
        u_ircrsa_mst.stop();
        cmd_busy <= 1'b0;
        test_done();
    end
endmodule
bind ircrsa_slave ircrsa_slave_asserts u_ircrsa_slave_asserts (
    .clk(clk), .rst_b(rst_b), .scl_i(scl_i), .sda_oe(sda_oe), .cmd_strobe(cmd_strobe), .cmd_busy(cmd_busy),
    .rtc_raddr(rtc_raddr), .rtc_we(rtc_we), .rtc_waddr(rtc_waddr), .mem_control(mem_control),
    .serial_lock_flag(serial_lock_flag));
`default_nettype wire
